// [rtl/motion_task_pkg.sv]
// Constants, types and state layout of the motion task handshake block
package motion_task_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;

    // Byte addresses of the register words
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_GOAL = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_POS = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_VEL = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_SPEED_CEIL = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_ACCEL = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_DECEL = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_MOVE_ARG = 6'h28;

    // Control word fields
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_CMD_LSB = 1;
    localparam int unsigned CMD_W = 3;

    // Status word fields
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_DONE = 1;
    localparam int unsigned ST_ABORT = 2;
    localparam int unsigned ST_ERR = 3;
    localparam int unsigned ST_GOAL_VALID = 4;
    localparam int unsigned ST_HOMED = 5;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_ABORT = 1;
    localparam int unsigned IRQ_ERR = 2;

    // Reset values of the software-written words
    localparam logic [DATA_W-1:0] SPEED_CEIL_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ACCEL_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DECEL_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [CMD_W-1:0] {
        fault_clear_command = 3'h0,
        homing_command = 3'h1,
        stop_axis_command = 3'h2,
        absolute_move_command = 3'h3,
        relative_move_command = 3'h4
    } cmd_t;

    typedef enum logic [1:0] {
        TASK_IDLE = 2'h0,
        TASK_BUSY = 2'h1,
        TASK_SHOW = 2'h3
    } task_state_t;

    typedef struct packed {
        task_state_t state;
        logic req;
        logic req_prev;
        logic [CMD_W-1:0] cmd_sel;
        cmd_t active_cmd;
        logic done;
        logic aborted;
        logic error;
        logic eng_start;
        logic homed;
        logic en_prev;
        logic [DATA_W-1:0] enable_ref;
        logic [DATA_W-1:0] move_arg;
        logic [DATA_W-1:0] goal;
        logic [DATA_W-1:0] speed_ceil;
        logic [DATA_W-1:0] accel;
        logic [DATA_W-1:0] decel;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic ack;
        logic [DATA_W-1:0] rdata;
    } state_t;

    function automatic logic cmd_known(logic [CMD_W-1:0] c);
        return c inside {fault_clear_command, homing_command, stop_axis_command,
                         absolute_move_command, relative_move_command};
    endfunction : cmd_known

    function automatic logic cmd_positions(cmd_t c);
        return (c == absolute_move_command) || (c == relative_move_command);
    endfunction : cmd_positions

endpackage : motion_task_pkg

// [rtl/motion_task_status_handshake.sv]
// Motion task start/status handshake with Avalon-MM register access
`timescale 1ns/1ns
module motion_task_status_handshake
    import motion_task_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic task_busy,
    output logic task_done,
    output logic task_superseded_flag,
    output logic task_error,
    output logic goal_valid,
    output logic [DATA_W-1:0] goal_position_value,
    output logic eng_start,
    output logic [CMD_W-1:0] eng_cmd,
    output logic [DATA_W-1:0] eng_speed_ceil,
    output logic [DATA_W-1:0] eng_accel,
    output logic [DATA_W-1:0] eng_decel,
    input wire logic eng_task_done,
    input wire logic eng_standstill,
    input wire logic eng_fault,
    input wire logic eng_supersede,
    input wire logic eng_axis_enabled,
    input wire logic [DATA_W-1:0] eng_position,
    input wire logic [DATA_W-1:0] eng_velocity
);

    state_t st_q;
    state_t st_d;

    logic bus_req;
    logic bus_take;
    logic start_edge;
    logic in_busy;
    logic err_ev;
    logic abort_ev;
    logic done_ev;
    logic bad_start;
    logic [IRQ_W-1:0] irq_ev;
    logic [DATA_W-1:0] pos_report;
    logic [DATA_W-1:0] rd_mux;

    assign bus_req = avs_read | avs_write;
    assign bus_take = bus_req & st_q.ack;
    assign avs_waitrequest = bus_req & ~st_q.ack;
    assign avs_readdata = st_q.rdata;

    // Edge of the software start request; a level held high gives no edge
    assign start_edge = st_q.req & ~st_q.req_prev;
    assign in_busy = (st_q.state == TASK_BUSY);
    assign bad_start = start_edge & (st_q.state != TASK_BUSY) & ~cmd_known(st_q.cmd_sel);

    // Error wins over supersede, supersede over completion, so results stay exclusive
    assign err_ev = (in_busy & eng_fault) | bad_start;
    assign abort_ev = in_busy & ~eng_fault & eng_supersede & (st_q.active_cmd != fault_clear_command);
    assign done_ev = in_busy & ~eng_fault & ~abort_ev & eng_task_done & eng_standstill;

    assign irq_ev = {err_ev, abort_ev, done_ev};

    // Position stays relative to where the axis was enabled until homing succeeds
    assign pos_report = st_q.homed ? eng_position : eng_position - st_q.enable_ref;

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            OFS_CTRL: begin
                rd_mux[CTRL_START_BIT] = st_q.req;
                rd_mux[CTRL_CMD_LSB +: CMD_W] = st_q.cmd_sel;
            end
            OFS_STATUS: begin
                rd_mux[ST_BUSY] = in_busy;
                rd_mux[ST_DONE] = st_q.done;
                rd_mux[ST_ABORT] = st_q.aborted;
                rd_mux[ST_ERR] = st_q.error;
                rd_mux[ST_GOAL_VALID] = goal_valid;
                rd_mux[ST_HOMED] = st_q.homed;
            end
            OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = st_q.irq_stat;
            OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = st_q.irq_mask;
            OFS_GOAL: rd_mux = st_q.goal;
            OFS_POS: rd_mux = pos_report;
            OFS_VEL: rd_mux = eng_velocity;
            OFS_SPEED_CEIL: rd_mux = st_q.speed_ceil;
            OFS_ACCEL: rd_mux = st_q.accel;
            OFS_DECEL: rd_mux = st_q.decel;
            OFS_MOVE_ARG: rd_mux = st_q.move_arg;
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.req_prev = st_q.req;
        st_d.eng_start = 1'b0;
        st_d.en_prev = eng_axis_enabled;

        // One wait state per access; data sampled on the first cycle stand on the second
        st_d.ack = bus_req & ~st_q.ack;
        if (avs_read && !st_q.ack) begin
            st_d.rdata = rd_mux;
        end

        if (avs_write && bus_take) begin
            case (avs_address)
                OFS_CTRL: begin
                    st_d.req = avs_writedata[CTRL_START_BIT];
                    st_d.cmd_sel = avs_writedata[CTRL_CMD_LSB +: CMD_W];
                end
                OFS_IRQ_MASK: st_d.irq_mask = avs_writedata[IRQ_W-1:0];
                OFS_SPEED_CEIL: st_d.speed_ceil = avs_writedata;
                OFS_ACCEL: st_d.accel = avs_writedata;
                OFS_DECEL: st_d.decel = avs_writedata;
                OFS_MOVE_ARG: st_d.move_arg = avs_writedata;
                default: st_d.irq_mask = st_q.irq_mask;
            endcase
        end

        // Only bits that the read returned are cleared, and a new event always wins
        if (avs_read && bus_take && avs_address == OFS_IRQ_STAT) begin
            st_d.irq_stat = st_q.irq_stat & ~st_q.rdata[IRQ_W-1:0];
        end
        st_d.irq_stat = st_d.irq_stat | irq_ev;

        if (eng_axis_enabled && !st_q.en_prev) begin
            st_d.enable_ref = eng_position;
        end

        case (st_q.state)
            TASK_IDLE, TASK_SHOW: begin
                if (start_edge) begin
                    st_d.done = 1'b0;
                    st_d.aborted = 1'b0;
                    st_d.error = 1'b0;
                    if (cmd_known(st_q.cmd_sel)) begin
                        st_d.state = TASK_BUSY;
                        st_d.active_cmd = cmd_t'(st_q.cmd_sel);
                        st_d.eng_start = 1'b1;
                        if (st_q.cmd_sel == relative_move_command) begin
                            st_d.goal = pos_report + st_q.move_arg;
                        end else if (st_q.cmd_sel == absolute_move_command) begin
                            st_d.goal = st_q.move_arg;
                        end
                    end else begin
                        st_d.state = TASK_SHOW;
                        st_d.error = 1'b1;
                    end
                end else if (st_q.state == TASK_SHOW && !st_q.req) begin
                    // Shown one cycle when the request was already low at the end
                    st_d.state = TASK_IDLE;
                    st_d.done = 1'b0;
                    st_d.aborted = 1'b0;
                    st_d.error = 1'b0;
                end
            end
            TASK_BUSY: begin
                // The request level is not looked at here, so lowering it cannot stop the task
                if (err_ev || abort_ev || done_ev) begin
                    st_d.state = TASK_SHOW;
                    st_d.error = err_ev;
                    st_d.aborted = abort_ev;
                    st_d.done = done_ev;
                    if (done_ev && st_q.active_cmd == homing_command) begin
                        st_d.homed = 1'b1;
                    end
                end
            end
            default: st_d.state = TASK_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{state: TASK_IDLE, active_cmd: fault_clear_command,
                      speed_ceil: SPEED_CEIL_RST, accel: ACCEL_RST, decel: DECEL_RST,
                      irq_mask: IRQ_MASK_RST, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign task_busy = in_busy;
    assign task_done = st_q.done;
    assign task_superseded_flag = st_q.aborted;
    assign task_error = st_q.error;
    assign goal_valid = in_busy & cmd_positions(st_q.active_cmd);
    assign goal_position_value = st_q.goal;
    assign eng_start = st_q.eng_start;
    assign eng_cmd = st_q.active_cmd;
    assign eng_speed_ceil = st_q.speed_ceil;
    assign eng_accel = st_q.accel;
    assign eng_decel = st_q.decel;
    assign irq = |(st_q.irq_stat & st_q.irq_mask);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_start_edge_only;
        $rose(task_busy) |-> $past(start_edge) && $past(st_q.req);
    endproperty
    a_start_edge_only: assert property (p_start_edge_only) else $error("busy rose without a start edge");

    property p_busy_after_start;
        (start_edge && !in_busy && cmd_known(st_q.cmd_sel)) |=> task_busy ##1 (task_busy || task_done
            || task_superseded_flag || task_error);
    endproperty
    a_busy_after_start: assert property (p_busy_after_start) else $error("busy not raised on start");

    property p_done_same_cycle;
        done_ev |=> !task_busy && task_done;
    endproperty
    a_done_same_cycle: assert property (p_done_same_cycle) else $error("done and busy not swapped together");

    property p_abort_same_cycle;
        abort_ev |=> !task_busy && task_superseded_flag;
    endproperty
    a_abort_same_cycle: assert property (p_abort_same_cycle) else $error("abort and busy not swapped");

    property p_error_same_cycle;
        (in_busy && eng_fault) |=> !task_busy && task_error;
    endproperty
    a_error_same_cycle: assert property (p_error_same_cycle) else $error("error and busy not swapped");

    property p_end_ignores_req;
        (in_busy && (eng_fault || eng_supersede && st_q.active_cmd != fault_clear_command
            || eng_task_done && eng_standstill)) |=> !task_busy;
    endproperty
    a_end_ignores_req: assert property (p_end_ignores_req) else $error("busy held after task end");

    property p_status_latched;
        ((task_done || task_superseded_flag || task_error) && st_q.req && !start_edge)
            |=> $stable({task_done, task_superseded_flag, task_error});
    endproperty
    a_status_latched: assert property (p_status_latched) else $error("final status lost while request high");

    property p_status_one_cycle;
        ((task_done || task_superseded_flag || task_error) && !st_q.req)
            |=> !(task_done || task_superseded_flag || task_error);
    endproperty
    a_status_one_cycle: assert property (p_status_one_cycle) else $error("final status outlived low request");

    property p_req_low_keeps_task;
        (in_busy && !st_q.req && !eng_fault && !eng_supersede && !eng_task_done) |=> task_busy;
    endproperty
    a_req_low_keeps_task: assert property (p_req_low_keeps_task) else $error("task stopped by request drop");

    property p_clear_not_superseded;
        (in_busy && st_q.active_cmd == fault_clear_command) |=> !task_superseded_flag;
    endproperty
    a_clear_not_superseded: assert property (p_clear_not_superseded) else $error("fault clear superseded");

    property p_done_at_standstill;
        $rose(task_done) |-> $past(eng_standstill) && $past(eng_task_done);
    endproperty
    a_done_at_standstill: assert property (p_done_at_standstill) else $error("done without standstill");

    property p_goal_valid_window;
        goal_valid |-> task_busy && (eng_cmd == absolute_move_command || eng_cmd == relative_move_command);
    endproperty
    a_goal_valid_window: assert property (p_goal_valid_window) else $error("goal valid outside a move");

    property p_results_exclusive;
        $onehot0({task_done, task_superseded_flag, task_error});
    endproperty
    a_results_exclusive: assert property (p_results_exclusive) else $error("more than one result flag");

    property p_wait_one;
        (bus_req && !st_q.ack) |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait state");

    c_done_held: cover property (done_ev && st_q.req ##1 task_done [*3]);
    c_abort_pulse: cover property (abort_ev && !st_q.req ##1 task_superseded_flag ##1 !task_superseded_flag);
    c_error_run: cover property ($rose(task_busy) ##[1:20] (in_busy && eng_fault));
    c_irq: cover property ($rose(irq));

endmodule : motion_task_status_handshake

// [tb/motion_engine_model.sv]
// Behavioural motion engine that answers each started task after a chosen delay
`timescale 1ns/1ns
module motion_engine_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic eng_start,
    input wire logic [1:0] outcome,
    input wire logic [7:0] delay,
    input wire logic enable_axis,
    output logic eng_task_done,
    output logic eng_standstill,
    output logic eng_fault,
    output logic eng_supersede,
    output logic eng_axis_enabled,
    output logic [31:0] eng_position,
    output logic [31:0] eng_velocity
);
    logic [7:0] left_q;
    logic second_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 8'h00;
            second_q <= 1'b0;
            eng_task_done <= 1'b0;
            eng_standstill <= 1'b1;
            eng_fault <= 1'b0;
            eng_supersede <= 1'b0;
            eng_axis_enabled <= 1'b0;
            eng_position <= 32'h0000_0100;
            eng_velocity <= 32'h0000_0000;
        end else begin
            eng_task_done <= 1'b0;
            eng_fault <= 1'b0;
            eng_supersede <= 1'b0;
            eng_axis_enabled <= enable_axis;
            if (eng_start) begin
                left_q <= delay;
                second_q <= 1'b0;
                eng_standstill <= 1'b0;
                eng_velocity <= 32'h0000_0001;
            end else if (left_q != 8'h00) begin
                left_q <= left_q - 8'h01;
                eng_position <= eng_position + 32'h0000_0001;
                if (left_q == 8'h01) begin
                    // A superseded fault clear keeps running, so it is finished a little later
                    if (outcome == 2'h3 && !second_q) begin
                        eng_supersede <= 1'b1;
                        second_q <= 1'b1;
                        left_q <= 8'h03;
                    end else begin
                        eng_task_done <= (outcome == 2'h0) || (outcome == 2'h3);
                        eng_supersede <= (outcome == 2'h1);
                        eng_fault <= (outcome == 2'h2);
                        eng_standstill <= 1'b1;
                        eng_velocity <= 32'h0000_0000;
                    end
                end
            end
        end
    end
endmodule : motion_engine_model

// [tb/motion_task_status_handshake_test.sv]
// Self-checking bench for the motion task handshake block
`timescale 1ns/1ns
module motion_task_status_handshake_test;
    import motion_task_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata, goal_position_value, eng_speed_ceil, eng_accel, eng_decel;
    logic [DATA_W-1:0] eng_position, eng_velocity, pos_ref, exp_goal;
    logic avs_waitrequest, irq, task_busy, task_done, task_superseded_flag, task_error, goal_valid;
    logic eng_start, eng_task_done, eng_standstill, eng_fault, eng_supersede, eng_axis_enabled;
    logic [CMD_W-1:0] eng_cmd;
    logic [1:0] outcome = 2'h0;
    logic [7:0] delay = 8'h0c;
    logic enable_axis = 1'b0;
    logic homed_seen = 1'b0;
    logic one_q = 1'b0;
    logic [2:0] prev_fl = 3'h0;
    logic [2:0] cur;
    logic [3:0] note;
    logic [31:0] seed = 32'd47991;
    logic [DATA_W-1:0] rd_q[$];
    logic [3:0] fl_q[$];
    int hi_len = 0;
    int err_total = 0;
    int check_count = 0;

    always #2 clock = ~clock;

    motion_task_status_handshake uut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .irq, .task_busy, .task_done, .task_superseded_flag, .task_error,
        .goal_valid, .goal_position_value, .eng_start, .eng_cmd, .eng_speed_ceil, .eng_accel, .eng_decel,
        .eng_task_done, .eng_standstill, .eng_fault, .eng_supersede, .eng_axis_enabled, .eng_position,
        .eng_velocity);
    motion_engine_model engine (.clock, .rst_n, .eng_start, .outcome, .delay, .enable_axis, .eng_task_done,
        .eng_standstill, .eng_fault, .eng_supersede, .eng_axis_enabled, .eng_position, .eng_velocity);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bits

    // Request held until waitrequest is sampled low at a rising edge; released at that same edge
    task automatic bus_req(input logic [ADDR_W-1:0] a, input logic rd, input logic [DATA_W-1:0] d);
        int i;
        @(posedge clock);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= d;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 40) begin
            err_total++;
            tally_and_finish();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_req

    task automatic bus_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        rd_q.push_back(exp);
        bus_req(a, 1'b1, '0);
    endtask : bus_read

    task automatic wait_flags(input logic want);
        for (int i = 0; i < 300; i++) begin
            @(negedge clock);
            if (((task_done | task_superseded_flag | task_error) === 1'b1) == want) return;
        end
        err_total++;
        tally_and_finish();
    endtask : wait_flags

    task automatic run_task(input logic [CMD_W-1:0] cmd, input logic [1:0] oc, input logic held);
        logic [2:0] exp;
        logic [DATA_W-1:0] arg;
        logic [DATA_W-1:0] st_exp;
        exp = (oc == 2'h2) ? 3'h4 : (oc == 2'h1) ? 3'h2 : 3'h1;
        arg = rnd();
        outcome <= oc;
        delay <= 8'h0c + 8'(rnd() & 32'h7);
        bus_req(OFS_MOVE_ARG, 1'b0, arg);
        exp_goal = (cmd == 3'h3) ? arg : arg + (homed_seen ? eng_position : eng_position - pos_ref);
        fl_q.push_back({~held, exp});
        bus_req(OFS_CTRL, 1'b0, {28'h0, cmd, 1'b1});
        if (!held) bus_req(OFS_CTRL, 1'b0, {28'h0, cmd, 1'b0});
        repeat (2) @(negedge clock);
        check_bits("busy", 4'h1, {3'h0, task_busy});
        check_bits("goal_valid", {3'h0, cmd == 3'h3 || cmd == 3'h4}, {3'h0, goal_valid});
        if (cmd == 3'h3 || cmd == 3'h4) check_word("goal", exp_goal, goal_position_value);
        check_bits("cmd", {1'b0, cmd}, {1'b0, eng_cmd});
        st_exp = '0;
        st_exp[ST_BUSY] = 1'b1;
        st_exp[ST_GOAL_VALID] = (cmd == 3'h3 || cmd == 3'h4);
        st_exp[ST_HOMED] = homed_seen;
        bus_read(OFS_STATUS, st_exp);
        if (cmd == 3'h3 || cmd == 3'h4) bus_read(OFS_GOAL, exp_goal);
        wait_flags(1'b1);
        if (held) begin
            // Same level written again is not a fresh edge
            bus_req(OFS_CTRL, 1'b0, {28'h0, cmd, 1'b1});
            repeat (3) @(negedge clock);
            check_bits("held", {1'b0, exp}, {task_busy, task_error, task_superseded_flag, task_done});
            bus_req(OFS_CTRL, 1'b0, {28'h0, cmd, 1'b0});
            repeat (2) @(negedge clock);
            check_bits("cleared", 4'h0, {1'b0, task_error, task_superseded_flag, task_done});
        end
        wait_flags(1'b0);
        check_bits("goal_idle", 4'h0, {3'h0, goal_valid});
        if (cmd == 3'h1 && oc == 2'h0) homed_seen = 1'b1;
    endtask : run_task

    // Watcher: takes the oldest note whenever read data or a task result appears
    // Read data is taken at the accepting edge, where the master takes it too
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check_word("readdata", rd_q.pop_front(), avs_readdata);
        end
    end

    always @(negedge clock) begin
        cur = {task_error, task_superseded_flag, task_done};
        if (cur !== 3'h0 && prev_fl === 3'h0) begin
            note = fl_q.pop_front();
            one_q = note[3];
            hi_len = 0;
            check_bits("result", {1'b0, note[2:0]}, {task_busy, cur});
        end
        if (cur !== 3'h0) hi_len++;
        if (cur === 3'h0 && prev_fl !== 3'h0 && one_q) check_bits("pulse", 4'h1, hi_len[3:0]);
        prev_fl = cur;
    end

    initial begin
        logic [ADDR_W-1:0] regs[6] = '{OFS_SPEED_CEIL, OFS_ACCEL, OFS_DECEL, OFS_IRQ_MASK, OFS_IRQ_STAT, 6'h2c};
        logic [DATA_W-1:0] wv[3];
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        enable_axis <= 1'b1;
        foreach (regs[i]) bus_read(regs[i], '0);
        pos_ref = eng_position;
        for (int k = 0; k < 3; k++) begin
            wv[k] = rnd();
            bus_req(regs[k], 1'b0, wv[k]);
            bus_read(regs[k], wv[k]);
        end
        check_word("speed_ceil", wv[0], eng_speed_ceil);
        check_word("accel", wv[1], eng_accel);
        check_word("decel", wv[2], eng_decel);
        bus_req(6'h3c, 1'b0, rnd());
        bus_read(6'h3c, '0);
        bus_read(OFS_VEL, eng_velocity);
        bus_read(OFS_POS, eng_position - pos_ref);
        for (int c = 0; c < 5; c++) begin
            for (int o = 0; o < 3; o++) begin
                run_task(3'(c), (c == 0 && o == 1) ? 2'h3 : 2'(o), 1'(rnd()));
            end
        end
        bus_read(OFS_POS, eng_position);
        // Unknown code ends at once in error without ever going busy
        fl_q.push_back(4'h4);
        bus_req(OFS_CTRL, 1'b0, 32'h0000_000b);
        wait_flags(1'b1);
        bus_req(OFS_CTRL, 1'b0, 32'h0000_000a);
        wait_flags(1'b0);
        // Empty the sticky bits first so the interrupt below can only come from this task
        bus_read(OFS_IRQ_STAT, 32'h0000_0007);
        bus_req(OFS_IRQ_MASK, 1'b0, 32'h0000_0001);
        @(negedge clock);
        check_bits("irq_idle", 4'h0, {3'h0, irq});
        run_task(3'h1, 2'h0, 1'b0);
        check_bits("irq_on", 4'h1, {3'h0, irq});
        bus_read(OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(negedge clock);
        check_bits("irq_off", 4'h0, {3'h0, irq});
        bus_req(OFS_IRQ_MASK, 1'b0, 32'h0000_0002);
        run_task(3'h2, 2'h2, 1'b0);
        check_bits("irq_masked", 4'h0, {3'h0, irq});
        bus_read(OFS_IRQ_STAT, 32'h0000_0004);
        repeat (4) @(negedge clock);
        tally_and_finish();
    end
endmodule : motion_task_status_handshake_test
